// file: dcc_bus_model.sv
// System bus model that grants the engine and ends each read cycle
`timescale 1ns/10ps
module dcc_bus_model (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Engine side
  input wire logic bus_req,
  input wire logic [3:0] gnt_wait,
  output logic bus_gnt,
  output logic rd_done
);
  logic [1:0] ph;
  logic [3:0] cnt;
  // Pulses only: one unit per grant, read end only after the grant
  always @(posedge clk) begin
    bus_gnt <= 1'b0;
    rd_done <= 1'b0;
    if (rst) begin
      ph <= 2'h0;
      cnt <= 4'h0;
    end else begin
      case (ph)
        2'h0: if (bus_req === 1'b1) begin
          cnt <= (cnt >= gnt_wait) ? 4'h0 : cnt + 4'h1;
          if (cnt >= gnt_wait) begin
            bus_gnt <= 1'b1;
            ph <= 2'h1;
          end
        end
        2'h1: begin
          cnt <= (cnt >= gnt_wait) ? 4'h0 : cnt + 4'h1;
          if (cnt >= gnt_wait) begin
            rd_done <= 1'b1;
            ph <= 2'h2;
          end
        end
        default: ph <= 2'h0;
      endcase
    end
  end
endmodule

// file: dcc_ctrl.sv
// Multi-channel DMA completion controller with AXI4-Lite registers
// Overview of operation
// - Set half flag at half-count read completion
// - Half flag raises interrupt when enabled
// - Half interrupt enable exists on channels 0-3
// - End interrupt after final read when enabled
// - End flag set when count reaches zero
// - Intermittent modes release bus, wait 16/64/256
`timescale 1ns/10ps
`include "dcc_regs.svh"
module dcc_ctrl import dcc_pkg::*; (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // AXI4-Lite slave
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Transfer requests and system bus
  input wire logic [5:0] xfer_req,
  input wire logic bus_gnt,
  input wire logic rd_done,
  output logic bus_req,
  output logic [2:0] act_ch,
  // Interrupts
  output logic half_irq,
  output logic dma_end_irq
);
  logic awready_r, awready_nxt, wready_r, wready_nxt, arready_r, arready_nxt;
  logic bvalid_r, bvalid_nxt, rvalid_r, rvalid_nxt;
  logic [1:0] bresp_r, bresp_nxt, rresp_r, rresp_nxt;
  logic [31:0] rdata_r, rdata_nxt, wd_r, wd_nxt, wv;
  logic [3:0] ws_r, ws_nxt;
  logic [7:0] aw_a_r, aw_a_nxt;
  logic aw_h_r, aw_h_nxt, w_h_r, w_h_nxt, wr_fire;
  logic [2:0] wch, rch, ch_r, ch_nxt;
  logic [5:0] en_r, en_nxt, ie_r, ie_nxt, hie_r, hie_nxt, te_r, te_nxt, he_r, he_nxt;
  logic [5:0] tes_r, tes_nxt, hes_r, hes_nxt, endp_r, endp_nxt;
  logic [`DCC_CNT_W-1:0] cnt_r [`DCC_NCH];
  logic [`DCC_CNT_W-1:0] cnt_nxt [`DCC_NCH];
  logic [`DCC_CNT_W-1:0] half_r [`DCC_NCH];
  logic [`DCC_CNT_W-1:0] half_nxt [`DCC_NCH];
  dcc_mode_e mode_r [`DCC_NCH];
  dcc_mode_e mode_nxt [`DCC_NCH];
  dcc_state_e state_r, state_nxt;
  logic bus_req_r, bus_req_nxt, half_irq_r, half_irq_nxt, end_irq_r, end_irq_nxt;
  logic found;

  dcc_gap_if gap ();
  dcc_gap_timer u_gap (
    .clk(clk),
    .rst(rst),
    .gap(gap)
  );

  function automatic logic addr_hit(input logic [7:0] a);
    return !a[7] && (a[6:4] < 3'(`DCC_NCH)) &&
      (a[3:0] == `DCC_CTRL_OFS || a[3:0] == `DCC_CNT_OFS);
  endfunction

  function automatic logic [31:0] ctrl_word(input int c);
    logic [31:0] v;
    v = `DCC_CTRL_RST;
    v[`DCC_B_EN] = en_r[c];
    v[`DCC_B_TE] = te_r[c];
    v[`DCC_B_IE] = ie_r[c];
    v[`DCC_B_MODE +: 2] = mode_r[c];
    v[`DCC_B_HIE] = hie_r[c];
    v[`DCC_B_HE] = he_r[c];
    return v;
  endfunction

  function automatic logic [31:0] reg_word(input logic [7:0] a, input int c);
    if (a[3:0] == `DCC_CTRL_OFS) begin
      return ctrl_word(c);
    end
    return {{(32 - `DCC_CNT_W){1'b0}}, cnt_r[c]};
  endfunction

  assign wch = aw_a_r[`DCC_CH_LSB +: 3];
  assign rch = s_axi_araddr[`DCC_CH_LSB +: 3];
  assign wr_fire = aw_h_r && w_h_r && !bvalid_r;

  always_comb begin
    awready_nxt = awready_r;
    wready_nxt = wready_r;
    arready_nxt = arready_r;
    bvalid_nxt = bvalid_r;
    rvalid_nxt = rvalid_r;
    bresp_nxt = bresp_r;
    rresp_nxt = rresp_r;
    rdata_nxt = rdata_r;
    wd_nxt = wd_r;
    ws_nxt = ws_r;
    aw_a_nxt = aw_a_r;
    aw_h_nxt = aw_h_r;
    w_h_nxt = w_h_r;
    en_nxt = en_r;
    ie_nxt = ie_r;
    hie_nxt = hie_r;
    te_nxt = te_r;
    he_nxt = he_r;
    tes_nxt = tes_r;
    hes_nxt = hes_r;
    endp_nxt = endp_r;
    cnt_nxt = cnt_r;
    half_nxt = half_r;
    mode_nxt = mode_r;
    state_nxt = state_r;
    ch_nxt = ch_r;
    bus_req_nxt = bus_req_r;
    found = 1'b0;
    wv = 32'h0000_0000;
    gap.start = 1'b0;
    gap.mode = mode_r[ch_r];

    if (s_axi_awvalid && awready_r) begin
      aw_h_nxt = 1'b1;
      aw_a_nxt = s_axi_awaddr;
    end
    if (s_axi_wvalid && wready_r) begin
      w_h_nxt = 1'b1;
      wd_nxt = s_axi_wdata;
      ws_nxt = s_axi_wstrb;
    end
    if (bvalid_r && s_axi_bready) begin
      bvalid_nxt = 1'b0;
    end
    if (wr_fire) begin
      aw_h_nxt = 1'b0;
      w_h_nxt = 1'b0;
      bvalid_nxt = 1'b1;
      bresp_nxt = addr_hit(aw_a_r) ? `DCC_RESP_OKAY : `DCC_RESP_SLVERR;
      if (addr_hit(aw_a_r)) begin
        // Unstrobed lanes keep their old value, so a flag there is never cleared
        wv = reg_word(aw_a_r, int'(wch));
        for (int b = 0; b < 4; b++) begin
          if (ws_r[b]) begin
            wv[b*8 +: 8] = wd_r[b*8 +: 8];
          end
        end
        if (aw_a_r[3:0] == `DCC_CTRL_OFS) begin
          en_nxt[wch] = wv[`DCC_B_EN];
          ie_nxt[wch] = wv[`DCC_B_IE];
          mode_nxt[wch] = dcc_mode_e'(wv[`DCC_B_MODE +: 2]);
          hie_nxt[wch] = (wch < 3'(`DCC_HALF_NCH)) && wv[`DCC_B_HIE];
          if (!wv[`DCC_B_TE] && tes_r[wch]) begin
            te_nxt[wch] = 1'b0;
            endp_nxt[wch] = 1'b0;
          end
          if (!wv[`DCC_B_HE] && hes_r[wch]) begin
            he_nxt[wch] = 1'b0;
          end
          tes_nxt[wch] = 1'b0;
          hes_nxt[wch] = 1'b0;
        end else begin
          cnt_nxt[wch] = wv[`DCC_CNT_W-1:0];
          half_nxt[wch] = wv[`DCC_CNT_W-1:0] >> 1;
        end
      end
    end
    awready_nxt = !aw_h_nxt && !bvalid_nxt;
    wready_nxt = !w_h_nxt && !bvalid_nxt;

    if (rvalid_r && s_axi_rready) begin
      rvalid_nxt = 1'b0;
    end
    if (s_axi_arvalid && arready_r) begin
      rvalid_nxt = 1'b1;
      rresp_nxt = addr_hit(s_axi_araddr) ? `DCC_RESP_OKAY : `DCC_RESP_SLVERR;
      rdata_nxt = 32'h0000_0000;
      if (addr_hit(s_axi_araddr)) begin
        rdata_nxt = reg_word(s_axi_araddr, int'(rch));
        if (s_axi_araddr[3:0] == `DCC_CTRL_OFS) begin
          tes_nxt[rch] = tes_nxt[rch] | te_r[rch];
          hes_nxt[rch] = hes_nxt[rch] | he_r[rch];
        end
      end
    end
    arready_nxt = !rvalid_nxt;

    // Engine updates follow the software ones, so a hardware set wins
    case (state_r)
      DCC_IDLE: begin
        if (!gap.busy) begin
          for (int c = `DCC_NCH - 1; c >= 0; c--) begin
            if (en_r[c] && xfer_req[c] && cnt_r[c] != '0) begin
              found = 1'b1;
              ch_nxt = 3'(c);
            end
          end
          if (found) begin
            state_nxt = DCC_REQ;
            bus_req_nxt = 1'b1;
          end
        end
      end
      DCC_REQ: begin
        if (bus_gnt) begin
          state_nxt = DCC_XFER;
          cnt_nxt[ch_r] = cnt_r[ch_r] - `DCC_CNT_W'(1);
          if (cnt_r[ch_r] == `DCC_CNT_W'(1)) begin
            te_nxt[ch_r] = 1'b1;
          end
        end
      end
      DCC_XFER: begin
        if (rd_done) begin
          state_nxt = DCC_IDLE;
          bus_req_nxt = 1'b0;
          gap.start = (mode_r[ch_r] != DCC_BURST);
          if (cnt_r[ch_r] == half_r[ch_r] && half_r[ch_r] != '0) begin
            he_nxt[ch_r] = 1'b1;
          end
          if (te_r[ch_r] && cnt_r[ch_r] == '0) begin
            endp_nxt[ch_r] = 1'b1;
          end
        end
      end
      default: begin
        state_nxt = DCC_IDLE;
        bus_req_nxt = 1'b0;
      end
    endcase
    half_irq_nxt = |(he_nxt[`DCC_HALF_NCH-1:0] & hie_nxt[`DCC_HALF_NCH-1:0]);
    end_irq_nxt = |(endp_nxt & ie_nxt);
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      awready_r <= 1'b0;
      wready_r <= 1'b0;
      arready_r <= 1'b0;
      bvalid_r <= 1'b0;
      rvalid_r <= 1'b0;
      bresp_r <= `DCC_RESP_OKAY;
      rresp_r <= `DCC_RESP_OKAY;
      rdata_r <= 32'h0000_0000;
      wd_r <= 32'h0000_0000;
      ws_r <= 4'h0;
      aw_a_r <= 8'h00;
      aw_h_r <= 1'b0;
      w_h_r <= 1'b0;
      en_r <= 6'h00;
      ie_r <= 6'h00;
      hie_r <= 6'h00;
      te_r <= 6'h00;
      he_r <= 6'h00;
      tes_r <= 6'h00;
      hes_r <= 6'h00;
      endp_r <= 6'h00;
      for (int c = 0; c < `DCC_NCH; c++) begin
        cnt_r[c] <= '0;
        half_r[c] <= '0;
        mode_r[c] <= DCC_BURST;
      end
      state_r <= DCC_IDLE;
      ch_r <= 3'h0;
      bus_req_r <= 1'b0;
      half_irq_r <= 1'b0;
      end_irq_r <= 1'b0;
    end else begin
      awready_r <= awready_nxt;
      wready_r <= wready_nxt;
      arready_r <= arready_nxt;
      bvalid_r <= bvalid_nxt;
      rvalid_r <= rvalid_nxt;
      bresp_r <= bresp_nxt;
      rresp_r <= rresp_nxt;
      rdata_r <= rdata_nxt;
      wd_r <= wd_nxt;
      ws_r <= ws_nxt;
      aw_a_r <= aw_a_nxt;
      aw_h_r <= aw_h_nxt;
      w_h_r <= w_h_nxt;
      en_r <= en_nxt;
      ie_r <= ie_nxt;
      hie_r <= hie_nxt;
      te_r <= te_nxt;
      he_r <= he_nxt;
      tes_r <= tes_nxt;
      hes_r <= hes_nxt;
      endp_r <= endp_nxt;
      cnt_r <= cnt_nxt;
      half_r <= half_nxt;
      mode_r <= mode_nxt;
      state_r <= state_nxt;
      ch_r <= ch_nxt;
      bus_req_r <= bus_req_nxt;
      half_irq_r <= half_irq_nxt;
      end_irq_r <= end_irq_nxt;
    end
  end

  assign s_axi_awready = awready_r;
  assign s_axi_wready = wready_r;
  assign s_axi_bresp = bresp_r;
  assign s_axi_bvalid = bvalid_r;
  assign s_axi_arready = arready_r;
  assign s_axi_rdata = rdata_r;
  assign s_axi_rresp = rresp_r;
  assign s_axi_rvalid = rvalid_r;
  assign bus_req = bus_req_r;
  assign act_ch = ch_r;
  assign half_irq = half_irq_r;
  assign dma_end_irq = end_irq_r;

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  half_set_a: assert property (
    state_r == DCC_XFER && rd_done && cnt_r[ch_r] == half_r[ch_r] && half_r[ch_r] != '0
    |=> he_r[$past(ch_r)]) else $error("half flag not set");
  half_irq_a: assert property (
    he_r[0] && hie_r[0] |-> half_irq) else $error("half interrupt missing");
  hie_gate_a: assert property (hie_r[5:4] == 2'b00 && !(half_irq &&
    (he_r[3:0] & hie_r[3:0]) == 4'h0 && $past(he_r[3:0] & hie_r[3:0]) == 4'h0))
    else $error("half enable outside channels 0-3");
  end_irq_a: assert property (
    state_r == DCC_XFER && rd_done && te_r[ch_r] && cnt_r[ch_r] == '0 && ie_r[ch_r]
    |=> ##1 dma_end_irq) else $error("end interrupt missing");
  te_set_a: assert property (
    state_r == DCC_REQ && bus_gnt && cnt_r[ch_r] == `DCC_CNT_W'(1)
    |=> te_r[$past(ch_r)] && cnt_r[$past(ch_r)] == '0) else $error("end flag not set");
  bus_hold_a: assert property (
    state_r == DCC_XFER && rd_done && mode_r[ch_r] != DCC_BURST
    |=> !bus_req [*8] ##1 gap.busy) else $error("bus regained too early");
  te_clear_a: assert property (
    wr_fire && addr_hit(aw_a_r) && aw_a_r[3:0] == `DCC_CTRL_OFS && te_r[wch] && !tes_r[wch]
    |=> te_r[$past(wch)]) else $error("end flag cleared without read");
  rst_clear_a: assert property (@(posedge clk) disable iff (1'b0)
    $past(rst) |-> en_r == 6'h00 && te_r == 6'h00 && he_r == 6'h00 && !dma_end_irq)
    else $error("control not zero after reset");

  final_cov_c: cover property (state_r == DCC_XFER && rd_done && te_r[ch_r]);
  half_cov_c: cover property (half_irq);
  steal_cov_c: cover property (gap.start && gap.mode == DCC_STEAL256);
  clear_cov_c: cover property (te_r[0] ##1 !te_r[0]);
endmodule

// file: dcc_gap_if.sv
// Handshake between the engine and the bus release gap timer
`timescale 1ns/10ps
interface dcc_gap_if;
  import dcc_pkg::*;
  logic start;
  dcc_mode_e mode;
  logic busy;
  modport tmr (input start, input mode, output busy);
  modport eng (output start, output mode, input busy);
endinterface

// file: dcc_gap_timer.sv
// Bus release gap timer for cycle-steal intermittent modes
`timescale 1ns/10ps
`include "dcc_regs.svh"
module dcc_gap_timer import dcc_pkg::*; (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Engine side
  dcc_gap_if.tmr gap
);
  logic [8:0] cnt_r;
  logic [8:0] cnt_nxt;

  always_comb begin
    cnt_nxt = cnt_r;
    if (gap.start) begin
      case (gap.mode)
        DCC_STEAL16: cnt_nxt = `DCC_GAP16;
        DCC_STEAL64: cnt_nxt = `DCC_GAP64;
        DCC_STEAL256: cnt_nxt = `DCC_GAP256;
        default: cnt_nxt = 9'h000;
      endcase
    end else if (cnt_r != 9'h000) begin
      cnt_nxt = cnt_r - 9'h001;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      cnt_r <= 9'h000;
    end else begin
      cnt_r <= cnt_nxt;
    end
  end

  assign gap.busy = (cnt_r != 9'h000);

  gap_len_a: assert property (@(posedge clk) disable iff (rst)
    gap.start && gap.mode == DCC_STEAL16 |=> gap.busy [*8] ##1 gap.busy [*8] ##1 !gap.busy)
    else $error("gap of 16 cycles not kept");
endmodule

// file: dcc_pkg.sv
// Types shared by the completion controller modules
package dcc_pkg;
  typedef enum logic [1:0] {
    DCC_IDLE = 2'b00,
    DCC_REQ = 2'b01,
    DCC_XFER = 2'b10
  } dcc_state_e;
  typedef enum logic [1:0] {
    DCC_BURST = 2'b00,
    DCC_STEAL16 = 2'b01,
    DCC_STEAL64 = 2'b10,
    DCC_STEAL256 = 2'b11
  } dcc_mode_e;
endpackage

// file: dcc_regs.svh
// Register offsets, field positions, reset values and timing counts
`ifndef DCC_REGS_SVH
`define DCC_REGS_SVH
`define DCC_NCH 6
`define DCC_HALF_NCH 4
`define DCC_CNT_W 24
`define DCC_CTRL_OFS 4'h0
`define DCC_CNT_OFS 4'h4
`define DCC_CH_LSB 4
`define DCC_B_EN 0
`define DCC_B_TE 1
`define DCC_B_IE 2
`define DCC_B_MODE 4
`define DCC_B_HIE 18
`define DCC_B_HE 19
`define DCC_CTRL_RST 32'h0000_0000
`define DCC_GAP16 9'h010
`define DCC_GAP64 9'h040
`define DCC_GAP256 9'h100
`define DCC_RESP_OKAY 2'h0
`define DCC_RESP_SLVERR 2'h2
`endif

// file: dcc_tb.sv
// Register and transfer tests of the completion controller
`timescale 1ns/10ps
`include "dcc_regs.svh"
`define CHK(n, e, s) begin num_checks++; if ((s) !== (e)) begin bad_count++; \
  $display("mismatch %s expected %h seen %h", n, e, s); end end
module testbench;
  import dcc_pkg::*;
  localparam logic [31:0] EN = 32'h1 << `DCC_B_EN;
  localparam logic [31:0] TE = 32'h1 << `DCC_B_TE;
  localparam logic [31:0] IE = 32'h1 << `DCC_B_IE;
  localparam logic [31:0] HALF_DONE_IRQ_EN = 32'h1 << `DCC_B_HIE;
  localparam logic [31:0] HE = 32'h1 << `DCC_B_HE;
  localparam logic [1:0] OK = `DCC_RESP_OKAY;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_arvalid = 1'b0;
  // Always ready for answers, which AXI allows
  logic s_axi_bready = 1'b1, s_axi_rready = 1'b1;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, rs;
  logic [5:0] xfer_req = 6'h00;
  logic bus_gnt, rd_done, bus_req, half_irq, dma_end_irq;
  logic [2:0] act_ch;
  logic [3:0] gnt_wait = 4'h0;
  logic req_d = 1'b0, hi_d = 1'b0, ei_d = 1'b0;
  int bad_count = 0, num_checks = 0, cyc = 0, last_rd = 0, gap = 0, units = 0, hat = 0, eat = 0;
  int gp [4] = '{0, `DCC_GAP16, `DCC_GAP64, `DCC_GAP256};
  always #2 clk = ~clk;
  dcc_ctrl dut_u (.clk, .rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .xfer_req, .bus_gnt, .rd_done, .bus_req, .act_ch, .half_irq, .dma_end_irq);
  dcc_bus_model bus_u (.clk, .rst, .bus_req, .gnt_wait, .bus_gnt, .rd_done);
  // Unit count at each interrupt rise, and idle span before each new request
  always @(posedge clk) begin
    cyc <= cyc + 1;
    req_d <= bus_req;
    hi_d <= half_irq;
    ei_d <= dma_end_irq;
    if (rd_done === 1'b1) begin
      last_rd <= cyc;
      units <= units + 1;
    end
    if (bus_req === 1'b1 && req_d === 1'b0) gap <= cyc - last_rd;
    if (half_irq === 1'b1 && hi_d === 1'b0) hat <= units;
    if (dma_end_irq === 1'b1 && ei_d === 1'b0) eat <= units;
  end
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic tmo(input string w);
    bad_count++;
    $display("mismatch %s expected answer seen none", w);
    report_and_stop();
  endtask
  function automatic logic [7:0] ad(input int c, input logic [3:0] o);
    return {c[3:0], o};
  endfunction
  task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    int n;
    logic aw, w;
    n = 0;
    aw = 1'b0;
    w = 1'b0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    do begin
      @(posedge clk);
      if (++n > 50) tmo("write");
      if (!aw && s_axi_awready === 1'b1) begin
        aw = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (!w && s_axi_wready === 1'b1) begin
        w = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
    end while (!(aw && w));
    do begin
      @(posedge clk);
      if (++n > 100) tmo("bresp");
    end while (s_axi_bvalid !== 1'b1);
    `CHK("bresp", er, s_axi_bresp)
  endtask
  task automatic axr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    n = 0;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do begin
      @(posedge clk);
      if (++n > 50) tmo("read");
    end while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    do begin
      @(posedge clk);
      if (++n > 100) tmo("rresp");
    end while (s_axi_rvalid !== 1'b1);
    d = s_axi_rdata;
    r = s_axi_rresp;
  endtask
  task automatic chkr(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er,
      input string nm);
    axr(a, rd, rs);
    `CHK(nm, e, rd)
    `CHK("rresp", er, rs)
  endtask
  // Polls the count until empty, then waits for the bus to be released
  task automatic wait_done(input int c);
    int n;
    n = 0;
    do begin
      axr(ad(c, `DCC_CNT_OFS), rd, rs);
      if (++n > 300) tmo("count");
    end while (rd[23:0] !== 24'h0);
    while (bus_req !== 1'b0) begin
      @(posedge clk);
      if (++n > 400) tmo("idle");
    end
    `CHK("act_ch", 3'(c), act_ch)
    n = 0;
    repeat (4) @(posedge clk);
  endtask
  initial begin
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    `CHK("outs_rst", 3'h0, {half_irq, dma_end_irq, bus_req})
    for (int c = 0; c < `DCC_NCH; c++)
      chkr(ad(c, `DCC_CTRL_OFS), `DCC_CTRL_RST, OK, "ctrl_rst");
    chkr(8'h68, 32'h0, `DCC_RESP_SLVERR, "unmapped");
    axw(8'h08, 32'hFFFFFFFF, `DCC_RESP_SLVERR);
    axw(ad(4, `DCC_CTRL_OFS), HALF_DONE_IRQ_EN, OK);
    chkr(ad(4, `DCC_CTRL_OFS), 32'h0, OK, "hie_ch4");
    // Slow grants; channel 0 runs four units with both interrupts enabled
    gnt_wait <= 4'h5;
    axw(ad(0, `DCC_CTRL_OFS), EN | IE | HALF_DONE_IRQ_EN, OK);
    axw(ad(0, `DCC_CNT_OFS), 32'h4, OK);
    xfer_req <= 6'h01;
    wait_done(0);
    `CHK("half_unit", units - 2, hat)
    `CHK("end_unit", units, eat)
    `CHK("irqs_on", 2'h3, {half_irq, dma_end_irq})
    // A clearing write with no read of 1 before it must be ignored
    axw(ad(0, `DCC_CTRL_OFS), EN | IE | HALF_DONE_IRQ_EN, OK);
    chkr(ad(0, `DCC_CTRL_OFS), EN | IE | HALF_DONE_IRQ_EN | TE | HE, OK, "flags_kept");
    axw(ad(0, `DCC_CTRL_OFS), EN | IE | HALF_DONE_IRQ_EN, OK);
    chkr(ad(0, `DCC_CTRL_OFS), EN | IE | HALF_DONE_IRQ_EN, OK, "flags_clr");
    `CHK("irqs_clr", 2'h0, {half_irq, dma_end_irq})
    axw(ad(1, `DCC_CTRL_OFS), EN, OK);
    axw(ad(1, `DCC_CNT_OFS), 32'h2, OK);
    xfer_req <= 6'h03;
    wait_done(1);
    chkr(ad(1, `DCC_CTRL_OFS), EN | TE | HE, OK, "flags_noirq");
    `CHK("irqs_off", 2'h0, {half_irq, dma_end_irq})
    gnt_wait <= 4'h0;
    for (int m = 0; m < 4; m++) begin
      axw(ad(2, `DCC_CTRL_OFS), EN | (32'(m) << `DCC_B_MODE), OK);
      axw(ad(2, `DCC_CNT_OFS), 32'h2, OK);
      xfer_req <= 6'h07;
      wait_done(2);
      `CHK("gap", 1'b1, gap >= gp[m] && gap <= gp[m] + 4)
    end
    report_and_stop();
  end
  initial begin
    repeat (50000) @(posedge clk);
    tmo("run");
  end
endmodule
